// ### sim/battery_model.sv
// battery_model: single-cell pack and charge current sense on the far side of the charger
// assumes the commanded current flows as measured; voltage is loaded by the bench
`timescale 1ns/1ps
module battery_model (
  // clock
  input wire logic mclk_i,
  // bench preset of the cell voltage
  input wire logic load_i,
  input wire logic [12:0] load_mv_i,
  // charger side
  input wire logic [9:0] drive_ma_i,
  output logic [12:0] batt_mv_o,
  output logic [9:0] charge_ma_o
);
  // cell rises 1mV a cycle under any current, so cv never settles and must end on current
  always_ff @(posedge mclk_i) begin
    if (load_i) batt_mv_o <= load_mv_i;
    else if (drive_ma_i != 10'h000) batt_mv_o <= batt_mv_o + 13'h0001;
  end
  assign charge_ma_o = drive_ma_i;
endmodule : battery_model

// ### sim/supply_charger_props.sv
// supply_charger_props: port checks for supply_event_and_charger_ctrl
// assumes clk_en_i held high and thermistor sensing left enabled
`timescale 1ns/1ps
module supply_charger_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // sources and conditions
  input wire logic usb_present_flag_i,
  input wire logic wall_present_flag_i,
  input wire logic battery_present_flag_i,
  input wire logic off_state_entry_i,
  input wire logic supply_normal_i,
  input wire logic source_is_usb_i,
  input wire logic usb_high_power_i,
  input wire logic pack_thermistor_present_i,
  input wire logic [12:0] supply_mv_i,
  input wire logic [12:0] batt_mv_i,
  // outputs
  input wire logic supply_change_summary_irq_o,
  input wire logic [9:0] charge_current_ma_o,
  input wire logic charging_in_progress_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [2:0] mask_ff;
  logic en_ff;
  logic [2:0] pres;
  logic rd_st;
  assign pres = {usb_present_flag_i, wall_present_flag_i, battery_present_flag_i};
  assign rd_st = reg_rd_i && reg_addr_i == 8'h1F;
  // shadows of the mask and the shared enable bit
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) mask_ff <= 3'h0;
    else if (reg_wr_i && reg_addr_i == 8'h27) mask_ff <= reg_wdata_i[15:13];
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || off_state_entry_i) en_ff <= 1'b1;
    else if (reg_wr_i && reg_addr_i == 8'h0C) en_ff <= reg_wdata_i[9];
    else if (reg_wr_i && reg_addr_i == 8'hA8) en_ff <= reg_wdata_i[15];
  end
  a_enable_gates: assert property (
    !en_ff [*3] |-> charge_current_ma_o == 10'h000 && !charging_in_progress_o)
    else $error("charging while disabled");
  a_thermistor_gate: assert property (
    !pack_thermistor_present_i [*3] |-> charge_current_ma_o == 10'h000)
    else $error("charging without thermistor");
  a_supply_gate: assert property (
    !supply_normal_i [*3] |-> !charging_in_progress_o)
    else $error("charging from bad supply");
  a_headroom_gate: assert property (
    ({1'b0, supply_mv_i} <= {1'b0, batt_mv_i} + 14'h0064) [*3]
    |-> charge_current_ma_o == 10'h000) else $error("charging without headroom");
  a_fast_cap: assert property (
    charge_current_ma_o <= 10'h2EE) else $error("current above fast maximum");
  a_usb_limit: assert property (
    source_is_usb_i [*3] |-> charge_current_ma_o <= (usb_high_power_i ? 10'h1F4 : 10'h064))
    else $error("usb current limit exceeded");
  a_edge_irq: assert property (
    ((|((pres ^ $past(pres)) & ~mask_ff)) && !rd_st) ##1 !rd_st
    |-> ##1 supply_change_summary_irq_o) else $error("presence change gave no irq");
  a_mask_read: assert property (
    reg_rd_i && reg_addr_i == 8'h27 |=> reg_rdata_o == {$past(mask_ff), 13'h0000})
    else $error("mask readback wrong");
  a_enable_read: assert property (
    reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o == {6'h00, $past(en_ff), 9'h000})
    else $error("enable readback wrong");
endmodule : supply_charger_props

bind supply_event_and_charger_ctrl supply_charger_props props_u (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .usb_present_flag_i(usb_present_flag_i), .wall_present_flag_i(wall_present_flag_i),
  .battery_present_flag_i(battery_present_flag_i), .off_state_entry_i(off_state_entry_i),
  .supply_normal_i(supply_normal_i), .source_is_usb_i(source_is_usb_i),
  .usb_high_power_i(usb_high_power_i), .pack_thermistor_present_i(pack_thermistor_present_i),
  .supply_mv_i(supply_mv_i), .batt_mv_i(batt_mv_i),
  .supply_change_summary_irq_o(supply_change_summary_irq_o),
  .charge_current_ma_o(charge_current_ma_o), .charging_in_progress_o(charging_in_progress_o));

// ### sim/test_supply_event_and_charger_ctrl.sv
// test_supply_event_and_charger_ctrl: register-level tests of events and charger
// assumes battery_model on the charge path and the bound property checker
`timescale 1ns/1ps
module test_supply_event_and_charger_ctrl;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [2:0] pres = 3'h7;
  logic off_entry = 1'b0;
  logic sup_ok = 1'b1;
  logic on_usb = 1'b0;
  logic hp = 1'b0;
  logic ntc_ok = 1'b1;
  logic t_fault = 1'b0;
  logic [12:0] sup_mv = 13'h1388;
  logic [12:0] batt_mv;
  logic [9:0] chg_ma;
  logic irq;
  logic [9:0] cur;
  logic prog;
  logic load = 1'b1;
  logic [12:0] load_mv = 13'h1004;
  logic [15:0] d;
  logic [12:0] tgt;
  int errors = 0;
  int n_tests = 0;
  int k;
  initial forever #12.5 mclk_i = ~mclk_i;
  supply_event_and_charger_ctrl dut_u (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .reg_wr_i(wr_en), .reg_rd_i(rd_en), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .usb_present_flag_i(pres[2]), .wall_present_flag_i(pres[1]),
    .battery_present_flag_i(pres[0]), .off_state_entry_i(off_entry),
    .supply_normal_i(sup_ok), .source_is_usb_i(on_usb), .usb_high_power_i(hp),
    .pack_thermistor_present_i(ntc_ok), .pack_temp_fault_i(t_fault),
    .supply_mv_i(sup_mv), .batt_mv_i(batt_mv), .charge_ma_i(chg_ma),
    .eoc_ma_i(10'h078), .system_usb_ma_i(10'h01E),
    .supply_change_summary_irq_o(irq), .charge_current_ma_o(cur),
    .charging_in_progress_o(prog));
  battery_model batt_u (.mclk_i(mclk_i), .load_i(load), .load_mv_i(load_mv),
    .drive_ma_i(cur), .batt_mv_o(batt_mv), .charge_ma_o(chg_ma));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk_i);
    wr_en <= 1'b0;
  endtask : wr
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    rd_en <= 1'b0;
    #1 d = rdata;
    chk(d, exp);
  endtask : rchk
  task automatic ld(input logic [12:0] v);
    @(posedge mclk_i);
    load <= 1'b1;
    load_mv <= v;
    @(posedge mclk_i);
    load <= 1'b0;
    #1;
  endtask : ld
  task automatic wrap_up();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    load <= 1'b0;
    rchk(8'h0C, 16'h0200);
    rchk(8'hA8, 16'h8001);
    rchk(8'hA9, 16'h0000);
    rchk(8'h27, 16'h0000);
    rchk(8'h55, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_i);
      pres[i] <= ~pres[i];
      tick(3);
      chk(16'(irq), 16'h0001);
      rchk(8'h1F, 16'h2000 << i);
      rchk(8'h1F, 16'h0000);
      tick(2);
      chk(16'(irq), 16'h0000);
      @(posedge mclk_i);
      pres[i] <= ~pres[i];
      tick(3);
      rchk(8'h1F, 16'h2000 << i);
    end
    wr(8'h27, 16'hE000);
    rchk(8'h27, 16'hE000);
    @(posedge mclk_i);
    pres <= ~pres;
    tick(3);
    chk(16'(irq), 16'h0000);
    wr(8'h27, 16'h0000);
    tick(2);
    chk(16'(irq), 16'h0001);
    rchk(8'h1F, 16'hE000);
    wr(8'h0C, 16'h0000);
    rchk(8'hA8, 16'h0001);
    wr(8'hA8, 16'h8001);
    rchk(8'h0C, 16'h0200);
    wr(8'h0C, 16'h0000);
    @(posedge mclk_i);
    off_entry <= 1'b1;
    @(posedge mclk_i);
    off_entry <= 1'b0;
    rchk(8'h0C, 16'h0200);
    ld(13'h0ED8);
    for (k = 0; k < 10 && prog !== 1'b1; k++) tick(1);
    tick(1);
    chk(16'(cur), 16'h0032);
    rchk(8'hA9, 16'h8001);
    wr(8'hA9, 16'h4000);
    tick(3);
    chk(16'(cur), 16'h0000);
    rchk(8'hA9, 16'h4000);
    wr(8'hA9, 16'h0040);
    tick(4);
    chk(16'(cur), 16'h0064);
    // one gating condition at a time, each must stop the current
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk_i);
      case (j)
        0: ntc_ok <= 1'b0;
        1: sup_ok <= 1'b0;
        2: sup_mv <= batt_mv + 13'h0064;
        default: t_fault <= 1'b1;
      endcase
      tick(4);
      chk(16'(cur), 16'h0000);
      @(posedge mclk_i);
      ntc_ok <= 1'b1;
      sup_ok <= 1'b1;
      sup_mv <= 13'h1388;
      t_fault <= 1'b0;
      tick(5);
      chk(16'(cur), 16'h0064);
    end
    wr(8'h0C, 16'h0000);
    tick(3);
    chk(16'(prog), 16'h0000);
    wr(8'h0C, 16'h0200);
    @(posedge mclk_i);
    on_usb <= 1'b1;
    tick(5);
    chk(16'(cur), 16'h0032);
    @(posedge mclk_i);
    on_usb <= 1'b0;
    for (k = 0; k < 300 && prog !== 1'b0; k++) tick(1);
    chk(16'(batt_mv >= 13'h0F6E), 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(8'hA9, 16'(c << 4));
      tgt = 13'h0FD2 + 13'(c * 13'h0032);
      ld(tgt - 13'h0064);
      tick(4);
      chk(16'(prog), 16'h0000);
      ld(tgt - 13'h0065);
      for (k = 0; k < 6 && prog !== 1'b1; k++) tick(1);
      chk(16'(prog), 16'h0001);
    end
    wr(8'hA9, 16'h0000);
    ld(13'h0F3C);
    wr(8'hA8, 16'h80F3);
    for (k = 0; k < 20 && cur !== 10'h2EE; k++) tick(1);
    chk(16'(cur), 16'h02EE);
    rchk(8'hA9, 16'h8003);
    @(posedge mclk_i);
    on_usb <= 1'b1;
    hp <= 1'b1;
    tick(3);
    chk(16'(cur), 16'h01D6);
    @(posedge mclk_i);
    on_usb <= 1'b0;
    tick(2);
    for (k = 0; k < 400 && cur === 10'h2EE; k++) tick(1);
    rchk(8'hA9, 16'h8002);
    chk(16'(batt_mv >= 13'h0FD2), 16'h0001);
    for (k = 0; k < 1000 && prog !== 1'b0; k++) tick(1);
    tick(1);
    chk(16'(cur), 16'h0000);
    wrap_up();
  end
endmodule : test_supply_event_and_charger_ctrl

// ### verilog/charge_phase_fsm.sv
// charge_phase_fsm: trickle and fast cc/cv sequencing with current setpoint
// assumes battery voltage and charge current measured in mV and mA each cycle
`timescale 1ns/1ps
module charge_phase_fsm (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // permission and requests
  input wire logic allow_i,
  input wire logic fast_ok_i,
  input wire logic fast_req_i,
  // measurements and targets
  input wire logic [12:0] batt_mv_i,
  input wire logic [12:0] target_mv_i,
  input wire logic [9:0] charge_ma_i,
  input wire logic [9:0] eoc_ma_i,
  input wire logic [9:0] trickle_ma_i,
  input wire logic [9:0] fast_ma_i,
  // state
  output supply_charger_pkg::charge_phase_t phase_o,
  output logic [9:0] setpoint_ma_o
);
  supply_charger_pkg::charge_phase_t nxt_phase;
  logic [9:0] nxt_setpoint;
  logic [12:0] start_mv;
  logic need_charge;

  assign start_mv = target_mv_i - supply_charger_pkg::HEADROOM_MV;
  assign need_charge = batt_mv_i < start_mv;

  always_comb begin
    nxt_phase = phase_o;
    nxt_setpoint = setpoint_ma_o;
    case (phase_o)
      supply_charger_pkg::CHG_IDLE: begin
        nxt_setpoint = '0;
        if (allow_i && need_charge) begin
          nxt_phase = supply_charger_pkg::CHG_TRICKLE;
          nxt_setpoint = trickle_ma_i;
        end
      end
      supply_charger_pkg::CHG_TRICKLE: begin
        nxt_setpoint = trickle_ma_i;
        if (fast_req_i && fast_ok_i) begin
          nxt_phase = supply_charger_pkg::CHG_FAST_CC;
          nxt_setpoint = fast_ma_i;
        end else if (charge_ma_i <= eoc_ma_i && !need_charge) begin
          nxt_phase = supply_charger_pkg::CHG_IDLE;
          nxt_setpoint = '0;
        end
      end
      supply_charger_pkg::CHG_FAST_CC: begin
        nxt_setpoint = fast_ma_i;
        if (batt_mv_i >= target_mv_i) begin
          nxt_phase = supply_charger_pkg::CHG_FAST_CV;
        end
      end
      supply_charger_pkg::CHG_FAST_CV: begin
        // regulate at target by walking the current down
        if (batt_mv_i >= target_mv_i && setpoint_ma_o > eoc_ma_i) begin
          nxt_setpoint = setpoint_ma_o - supply_charger_pkg::CV_STEP_MA;
        end
        if (charge_ma_i <= eoc_ma_i) begin
          nxt_phase = supply_charger_pkg::CHG_IDLE;
          nxt_setpoint = '0;
        end
      end
      default: begin
        nxt_phase = supply_charger_pkg::CHG_IDLE;
        nxt_setpoint = '0;
      end
    endcase
    // lost permission stops at once; the phase decision restarts from idle
    if (!allow_i) begin
      nxt_phase = supply_charger_pkg::CHG_IDLE;
      nxt_setpoint = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phase_o <= supply_charger_pkg::CHG_IDLE;
      setpoint_ma_o <= '0;
    end else if (clk_en_i) begin
      phase_o <= nxt_phase;
      setpoint_ma_o <= nxt_setpoint;
    end
  end
endmodule : charge_phase_fsm

// ### verilog/presence_edge_flags.sv
// presence_edge_flags: per-supply change detector with sticky clear-on-read flags
// assumes presence levels synchronous to mclk_i
`timescale 1ns/1ps
module presence_edge_flags #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // presence levels
  input wire logic [N-1:0] present_i,
  // clear strobe from a status read
  input wire logic clear_i,
  // sticky flags
  output logic [N-1:0] flags_o
);
  logic [N-1:0] prev_ff;
  logic primed_ff;

  if (N < 1) begin : g_bad_n
    $error("presence_edge_flags needs at least one supply");
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      primed_ff <= 1'b0;
    end else if (clk_en_i) begin
      primed_ff <= 1'b1;
    end
  end

  // no reset capture of the levels: the first cycle after release only primes
  always_ff @(posedge mclk_i) begin
    if (clk_en_i) begin
      prev_ff <= present_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          flags_o[g] <= 1'b0;
        end else if (clk_en_i) begin
          // an edge in the read cycle survives the clear
          if (primed_ff && (present_i[g] != prev_ff[g])) begin
            flags_o[g] <= 1'b1;
          end else if (clear_i) begin
            flags_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule : presence_edge_flags

// ### verilog/supply_charger_pkg.sv
// supply event and charger control: register map, field positions, reset values, states
// assumes a 16-bit register port with 8-bit addresses
package supply_charger_pkg;
  localparam int REG_AW = 8;
  localparam int REG_DW = 16;
  localparam logic [7:0] ADDR_POWER_MGMT_FIVE = 8'h0C;
  localparam logic [7:0] ADDR_SUPPLY_CHANGE_STATUS = 8'h1F;
  localparam logic [7:0] ADDR_SUPPLY_CHANGE_MASK = 8'h27;
  localparam logic [7:0] ADDR_CHARGER_CONTROL_ONE = 8'hA8;
  localparam logic [7:0] ADDR_CHARGER_CONTROL_TWO = 8'hA9;
  // presence-change flags and their masks
  localparam int NUM_SUPPLIES = 3;
  localparam int BIT_EVT_LO = 13;
  localparam int BIT_EVT_HI = 15;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // charger fields
  localparam int BIT_ENA_PM5 = 9;
  localparam int BIT_ENA_CC1 = 15;
  localparam int BIT_ACTIVE = 15;
  localparam int BIT_HOLD = 14;
  localparam int BIT_TRICKLE_SEL = 6;
  localparam int BIT_VSEL_LO = 4;
  localparam int BIT_VSEL_HI = 5;
  localparam int BIT_TEMP_SENSE = 0;
  localparam int BIT_FAST_REQ = 1;
  localparam int BIT_ISEL_LO = 4;
  localparam int BIT_ISEL_HI = 7;
  localparam int BIT_PHASE_LO = 0;
  localparam int BIT_PHASE_HI = 1;
  localparam logic ENA_RESET = 1'h1;
  localparam logic HOLD_RESET = 1'h0;
  localparam logic TEMP_SENSE_RESET = 1'h1;
  localparam logic TRICKLE_SEL_RESET = 1'h0;
  localparam logic [1:0] VSEL_RESET = 2'h0;
  localparam logic [3:0] ISEL_RESET = 4'h0;
  // voltages in mV, currents in mA
  localparam int MV_W = 13;
  localparam logic [12:0] HEADROOM_MV = 13'd100;
  localparam logic [12:0] VSEL_BASE_MV = 13'd4050;
  localparam logic [12:0] VSEL_STEP_MV = 13'd50;
  localparam logic [12:0] FAST_MIN_BATT_MV = 13'd3100;
  localparam int MA_W = 10;
  localparam logic [9:0] TRICKLE_LO_MA = 10'd50;
  localparam logic [9:0] TRICKLE_HI_MA = 10'd100;
  localparam logic [9:0] FAST_BASE_MA = 10'd50;
  localparam logic [9:0] FAST_STEP_MA = 10'd50;
  localparam logic [9:0] FAST_MAX_MA = 10'd750;
  localparam logic [9:0] USB_LOW_MA = 10'd100;
  localparam logic [9:0] USB_HIGH_MA = 10'd500;
  localparam logic [9:0] CV_STEP_MA = 10'd1;
  // gray-coded charger phases
  typedef enum logic [1:0] {
    CHG_IDLE = 2'b00,
    CHG_TRICKLE = 2'b01,
    CHG_FAST_CC = 2'b11,
    CHG_FAST_CV = 2'b10
  } charge_phase_t;
endpackage : supply_charger_pkg

// ### verilog/supply_event_and_charger_ctrl.sv
// supply_event_and_charger_ctrl: supply-presence events and charger supervision
// assumes a synchronous register port (one-cycle strobes) and measurement inputs in mV/mA
`timescale 1ns/1ps
// Contract
// - three supply events under one summary interrupt
// - event on either edge of presence
// - flags at bits 15:13, cleared by read
// - mask bits 15:13, one masks, reset zero
// - charger enabled by default, also on off entry
// - charge only with good supply, 100mV headroom
// - enable bit 9 resets 1; 0 zeroes current
// - enable mirrored at bit 15, one storage
// - enabled charger runs itself autonomously
// - read-only active bit 15 shows real charging
// - hold bit 14 pauses, keeps settings
// - target field 5:4 picks 4.05 to 4.2V
// - trickle default 50mA, 100mA selectable
// - fast 50 to 750mA, only when allowed
// - trickle starts low, ends at end-of-charge
// - fast cc to target then cv
// - fast ends at end-of-charge current in cv
// - thermistor sensing enabled out of reset
// - missing thermistor is fault, blocks charging
// - usb charging within 100 or 500mA limit
// - trickle starts 100mV below target
module supply_event_and_charger_ctrl #(
  parameter int NUM_SUPPLIES = supply_charger_pkg::NUM_SUPPLIES
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // supply presence: usb, wall, battery
  input wire logic usb_present_flag_i,
  input wire logic wall_present_flag_i,
  input wire logic battery_present_flag_i,
  // power state and supply condition
  input wire logic off_state_entry_i,
  input wire logic supply_normal_i,
  input wire logic source_is_usb_i,
  input wire logic usb_high_power_i,
  input wire logic pack_thermistor_present_i,
  input wire logic pack_temp_fault_i,
  // measurements
  input wire logic [12:0] supply_mv_i,
  input wire logic [12:0] batt_mv_i,
  input wire logic [9:0] charge_ma_i,
  input wire logic [9:0] eoc_ma_i,
  input wire logic [9:0] system_usb_ma_i,
  // outputs
  output logic supply_change_summary_irq_o,
  output logic [9:0] charge_current_ma_o,
  output logic charging_in_progress_o
);
  localparam int LO = supply_charger_pkg::BIT_EVT_LO;
  localparam int HI = supply_charger_pkg::BIT_EVT_HI;

  if (NUM_SUPPLIES != HI - LO + 1) begin : g_bad_count
    $error("supply count must match flag field");
  end

  logic [NUM_SUPPLIES-1:0] flags;
  logic [NUM_SUPPLIES-1:0] mask_ff;
  logic charger_enable_request_ff;
  logic charger_hold_ff;
  logic [1:0] charge_target_voltage_sel_ff;
  logic trickle_sel_ff;
  logic temp_sense_ff;
  logic fast_req_ff;
  logic [3:0] fast_isel_ff;
  logic status_read;
  logic allow;
  logic fast_ok;
  logic temp_ok;
  logic [12:0] target_mv;
  logic [9:0] trickle_ma;
  logic [9:0] fast_ma;
  logic [9:0] fast_raw;
  logic [9:0] usb_limit;
  logic [9:0] usb_room;
  logic [9:0] setpoint;
  logic [9:0] nxt_current;
  logic [15:0] nxt_rdata;
  supply_charger_pkg::charge_phase_t phase;

  assign status_read = reg_rd_i && (reg_addr_i == supply_charger_pkg::ADDR_SUPPLY_CHANGE_STATUS);

  // three flags grouped under one summary
  presence_edge_flags #(
    .N(NUM_SUPPLIES)
  ) u_flags (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .present_i({usb_present_flag_i, wall_present_flag_i, battery_present_flag_i}),
    .clear_i(status_read),
    .flags_o(flags)
  );

  // mask register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mask_ff <= supply_charger_pkg::MASK_RESET;
    end else if (clk_en_i && reg_wr_i
                 && reg_addr_i == supply_charger_pkg::ADDR_SUPPLY_CHANGE_MASK) begin
      mask_ff <= reg_wdata_i[HI:LO];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      supply_change_summary_irq_o <= 1'b0;
    end else if (clk_en_i) begin
      supply_change_summary_irq_o <= |(flags & ~mask_ff);
    end
  end

  // single enable bit reached at two addresses
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      charger_enable_request_ff <= supply_charger_pkg::ENA_RESET;
    end else if (clk_en_i) begin
      if (off_state_entry_i) begin
        charger_enable_request_ff <= supply_charger_pkg::ENA_RESET;
      end else if (reg_wr_i && reg_addr_i == supply_charger_pkg::ADDR_POWER_MGMT_FIVE) begin
        charger_enable_request_ff <= reg_wdata_i[supply_charger_pkg::BIT_ENA_PM5];
      end else if (reg_wr_i
                   && reg_addr_i == supply_charger_pkg::ADDR_CHARGER_CONTROL_ONE) begin
        charger_enable_request_ff <= reg_wdata_i[supply_charger_pkg::BIT_ENA_CC1];
      end
    end
  end

  // charger control two: hold, trickle select, target voltage
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      charger_hold_ff <= supply_charger_pkg::HOLD_RESET;
      trickle_sel_ff <= supply_charger_pkg::TRICKLE_SEL_RESET;
      charge_target_voltage_sel_ff <= supply_charger_pkg::VSEL_RESET;
    end else if (clk_en_i && reg_wr_i
                 && reg_addr_i == supply_charger_pkg::ADDR_CHARGER_CONTROL_TWO) begin
      charger_hold_ff <= reg_wdata_i[supply_charger_pkg::BIT_HOLD];
      trickle_sel_ff <= reg_wdata_i[supply_charger_pkg::BIT_TRICKLE_SEL];
      charge_target_voltage_sel_ff <=
        reg_wdata_i[supply_charger_pkg::BIT_VSEL_HI:supply_charger_pkg::BIT_VSEL_LO];
    end
  end

  // charger control one low bits: thermistor sense, fast request, fast current code
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      temp_sense_ff <= supply_charger_pkg::TEMP_SENSE_RESET;
      fast_req_ff <= 1'b0;
      fast_isel_ff <= supply_charger_pkg::ISEL_RESET;
    end else if (clk_en_i && reg_wr_i
                 && reg_addr_i == supply_charger_pkg::ADDR_CHARGER_CONTROL_ONE) begin
      temp_sense_ff <= reg_wdata_i[supply_charger_pkg::BIT_TEMP_SENSE];
      fast_req_ff <= reg_wdata_i[supply_charger_pkg::BIT_FAST_REQ];
      fast_isel_ff <=
        reg_wdata_i[supply_charger_pkg::BIT_ISEL_HI:supply_charger_pkg::BIT_ISEL_LO];
    end
  end

  // target: base plus 50mV per code step
  assign target_mv = supply_charger_pkg::VSEL_BASE_MV
                     + supply_charger_pkg::VSEL_STEP_MV
                     * {11'h000, charge_target_voltage_sel_ff};
  assign trickle_ma = trickle_sel_ff ? supply_charger_pkg::TRICKLE_HI_MA
                                     : supply_charger_pkg::TRICKLE_LO_MA;
  assign fast_raw = supply_charger_pkg::FAST_BASE_MA
                    + supply_charger_pkg::FAST_STEP_MA * {6'h00, fast_isel_ff};
  assign fast_ma = (fast_raw > supply_charger_pkg::FAST_MAX_MA)
                   ? supply_charger_pkg::FAST_MAX_MA : fast_raw;

  // a missing thermistor counts as a temperature failure while sensing is on
  assign temp_ok = !temp_sense_ff || (pack_thermistor_present_i && !pack_temp_fault_i);

  assign allow = charger_enable_request_ff && !charger_hold_ff && temp_ok
                 && supply_normal_i
                 && (supply_mv_i > batt_mv_i + supply_charger_pkg::HEADROOM_MV);
  assign fast_ok = (!source_is_usb_i || usb_high_power_i)
                   && (batt_mv_i > supply_charger_pkg::FAST_MIN_BATT_MV);

  charge_phase_fsm u_phase (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .allow_i(allow),
    .fast_ok_i(fast_ok),
    .fast_req_i(fast_req_ff),
    .batt_mv_i(batt_mv_i),
    .target_mv_i(target_mv),
    .charge_ma_i(charge_ma_i),
    .eoc_ma_i(eoc_ma_i),
    .trickle_ma_i(trickle_ma),
    .fast_ma_i(fast_ma),
    .phase_o(phase),
    .setpoint_ma_o(setpoint)
  );

  // usb budget left after the system load
  assign usb_limit = usb_high_power_i ? supply_charger_pkg::USB_HIGH_MA
                                      : supply_charger_pkg::USB_LOW_MA;
  assign usb_room = (system_usb_ma_i >= usb_limit) ? '0 : usb_limit - system_usb_ma_i;

  always_comb begin
    nxt_current = setpoint;
    if (source_is_usb_i && nxt_current > usb_room) begin
      // trickle cannot be throttled finely, so it steps down or stops
      if (phase == supply_charger_pkg::CHG_TRICKLE) begin
        nxt_current = (usb_room >= supply_charger_pkg::TRICKLE_LO_MA)
                      ? supply_charger_pkg::TRICKLE_LO_MA : '0;
      end else begin
        nxt_current = usb_room;
      end
    end
    if (!allow) begin
      nxt_current = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      charge_current_ma_o <= '0;
      charging_in_progress_o <= 1'b0;
    end else if (clk_en_i) begin
      charge_current_ma_o <= nxt_current;
      charging_in_progress_o <= (phase != supply_charger_pkg::CHG_IDLE) && allow;
    end
  end

  // read data
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr_i)
      supply_charger_pkg::ADDR_POWER_MGMT_FIVE: begin
        nxt_rdata[supply_charger_pkg::BIT_ENA_PM5] = charger_enable_request_ff;
      end
      supply_charger_pkg::ADDR_SUPPLY_CHANGE_STATUS: begin
        nxt_rdata[HI:LO] = flags;
      end
      supply_charger_pkg::ADDR_SUPPLY_CHANGE_MASK: begin
        nxt_rdata[HI:LO] = mask_ff;
      end
      supply_charger_pkg::ADDR_CHARGER_CONTROL_ONE: begin
        nxt_rdata[supply_charger_pkg::BIT_ENA_CC1] = charger_enable_request_ff;
        nxt_rdata[supply_charger_pkg::BIT_ISEL_HI:supply_charger_pkg::BIT_ISEL_LO] =
          fast_isel_ff;
        nxt_rdata[supply_charger_pkg::BIT_FAST_REQ] = fast_req_ff;
        nxt_rdata[supply_charger_pkg::BIT_TEMP_SENSE] = temp_sense_ff;
      end
      supply_charger_pkg::ADDR_CHARGER_CONTROL_TWO: begin
        nxt_rdata[supply_charger_pkg::BIT_ACTIVE] = charging_in_progress_o;
        nxt_rdata[supply_charger_pkg::BIT_HOLD] = charger_hold_ff;
        nxt_rdata[supply_charger_pkg::BIT_TRICKLE_SEL] = trickle_sel_ff;
        nxt_rdata[supply_charger_pkg::BIT_VSEL_HI:supply_charger_pkg::BIT_VSEL_LO] =
          charge_target_voltage_sel_ff;
        nxt_rdata[supply_charger_pkg::BIT_PHASE_HI:supply_charger_pkg::BIT_PHASE_LO] = phase;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (clk_en_i && reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end
endmodule : supply_event_and_charger_ctrl
